// *** ssclk_defines.svh ***
// Offsets, field positions, reset values and timing counts of the system clock source select block
`ifndef SSCLK_DEFINES_SVH
`define SSCLK_DEFINES_SVH

// Register byte offsets
`define SSCLK_OFS_SYS_CFG      8'h00
`define SSCLK_OFS_LOOP_CFG     8'h04
`define SSCLK_OFS_DIV_CFG      8'h08
`define SSCLK_OFS_STATUS       8'h0c

// system_clock_config fields
`define SSCLK_SYS_SEL_LSB      0
`define SSCLK_SYS_SEL_MSB      1
`define SSCLK_SYS_REF_BIT      2
`define SSCLK_SYS_FR_EN_BIT    3

// loop_config_zero fields
`define SSCLK_LOOP_BYP_BIT     0
`define SSCLK_LOOP_BAND_LSB    1
`define SSCLK_LOOP_BAND_MSB    2
`define SSCLK_LOOP_INPUT_DIVIDE_FIELD_LSB    3
`define SSCLK_LOOP_INPUT_DIVIDE_FIELD_MSB    6
`define SSCLK_LOOP_FEEDBACK_MULTIPLY_FIELD_LSB    7
`define SSCLK_LOOP_FEEDBACK_MULTIPLY_FIELD_MSB    13

// divider_config fields
`define SSCLK_DIV_K1_LSB       0
`define SSCLK_DIV_K1_MSB       9
`define SSCLK_DIV_K2_LSB       16
`define SSCLK_DIV_K2_MSB       22

// status fields
`define SSCLK_ST_SEL_LSB       0
`define SSCLK_ST_SEL_MSB       1
`define SSCLK_ST_SWITCH_BIT    2
`define SSCLK_ST_LOCK_BIT      3
`define SSCLK_ST_BAND_OK_BIT   4
`define SSCLK_ST_FR_LOCK_BIT   5
`define SSCLK_ST_NCUR_LSB      8
`define SSCLK_ST_NCUR_MSB      15
`define SSCLK_ST_FR_MHZ_LSB    16
`define SSCLK_ST_FR_MHZ_MSB    24

// Reset values
`define SSCLK_RST_SYS_CFG      32'h0000_0000
`define SSCLK_RST_LOOP_CFG     32'h0000_0001
`define SSCLK_RST_DIV_CFG      32'h0000_0000

// VCO band limits in MHz, controlled mode
`define SSCLK_BAND0_MIN_MHZ    48
`define SSCLK_BAND0_MAX_MHZ    112
`define SSCLK_BAND1_MIN_MHZ    96
`define SSCLK_BAND1_MAX_MHZ    200
`define SSCLK_FR_VCO_MHZ       480

// Timing
`define SSCLK_CLK_PERIOD_NS    25
`define SSCLK_WIN_NS           1000
`define SSCLK_WIN_CYC          (`SSCLK_WIN_NS / `SSCLK_CLK_PERIOD_NS)
`define SSCLK_FR_LOCK_NS       1000
`define SSCLK_FR_LOCK_CYC      ((`SSCLK_FR_LOCK_NS + `SSCLK_CLK_PERIOD_NS - 1) / `SSCLK_CLK_PERIOD_NS)

`endif

// *** ssclk_pkg.sv ***
// Types of the system clock source select block
package ssclk_pkg;

  typedef enum logic [1:0] {
    SSCLK_SEL_WAKE   = 2'b00,
    SSCLK_SEL_RSVD   = 2'b01,
    SSCLK_SEL_GEN    = 2'b10,
    SSCLK_SEL_DIRECT = 2'b11
  } ssclk_sel_t;

  typedef enum logic [1:0] {
    SSCLK_SW_RUN  = 2'b00,
    SSCLK_SW_PARK = 2'b01,
    SSCLK_SW_ARM  = 2'b10
  } ssclk_sw_t;

  // Clock path key: what the output multiplexer is following
  typedef struct packed {
    ssclk_sel_t sel;
    logic       vco_bypass;
    logic       ref_onchip;
  } ssclk_key_t;

  // Raw clock levels arriving on pins or from on-chip sources
  typedef struct packed {
    logic ext_pin_one;
    logic crystal;
    logic onchip;
    logic wakeup;
  } ssclk_pins_t;

endpackage : ssclk_pkg

// *** ssclk_sync.sv ***
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module ssclk_sync #(
  parameter int W = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else if (i_ce) begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : ssclk_sync

// *** ssclk_pulse_div.sv ***
// Pulse divider: one tick out for every (div + 1) pulses in
`timescale 1ns/1ps
module ssclk_pulse_div #(
  parameter int W = 10
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic         i_clear,
  input  wire logic         i_pulse,
  input  wire logic [W-1:0] i_div,
  output logic              o_tick
);
  logic [W-1:0] count;
  wire          wrap = (count >= i_div);

  // Any factor 1..2^W works, odd ones included, since each input pulse is one half period
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count  <= '0;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      if (i_clear) begin
        count  <= '0;
        o_tick <= 1'b0;
      end else if (i_pulse) begin
        count  <= wrap ? '0 : count + 1'b1;
        o_tick <= wrap;
      end else begin
        o_tick <= 1'b0;
      end
    end
  end
endmodule : ssclk_pulse_div

// *** ssclk_top.sv ***
// System clock source select: direct drive, prescaler, behavioural PLL, wakeup clock
//
// Functional notes
// - Select 11 drives the system clock straight from external pin one.
// - Crystal reference with prescale factor one equals direct drive from crystal.
// - Select 10 with VCO bypass set divides oscillator by prescaler field plus one.
// - Prescaler source is the crystal input or the on-chip clock.
// - Factor one copies the oscillator, duty cycle included.
// - Largest prescaler setting divides by 1024.
// - Select 10 with VCO bypass clear enables the PLL as system clock.
// - PLL factor is N over P times K2, each field plus one.
// - PLL reference is the crystal input or the on-chip clock.
// - PLL approaches its target gradually, never jumping in frequency; here only N steps, P and K2 changes apply at once.
// - System clock in PLL mode is VCO divided by K2.
// - Band select picks VCO range 48-112 MHz or 96-200 MHz.
// - Dedicated FlexRay PLL runs its VCO at exactly 480 MHz.
// - Select 00 runs the system clock from the wakeup clock.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "ssclk_defines.svh"
module ssclk_top
  import ssclk_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_ext_clk_pin_one,
  input  wire logic        i_crystal_input_pin,
  input  wire logic        i_onchip_clk,
  input  wire logic        i_wakeup_clk,
  output logic             o_sys_clk,
  output logic             o_pll_locked,
  output logic             o_flexray_locked
);

  // Register storage
  logic [31:0] system_clock_config;
  logic [31:0] loop_config_zero;
  logic [31:0] divider_config;

  // Field views
  wire ssclk_sel_t  clock_source_select     = ssclk_sel_t'(system_clock_config[`SSCLK_SYS_SEL_MSB:`SSCLK_SYS_SEL_LSB]);
  wire              ref_onchip              = system_clock_config[`SSCLK_SYS_REF_BIT];
  wire              flexray_pll_enable      = system_clock_config[`SSCLK_SYS_FR_EN_BIT];
  wire              vco_bypass              = loop_config_zero[`SSCLK_LOOP_BYP_BIT];
  wire [1:0]        vco_band_select         = loop_config_zero[`SSCLK_LOOP_BAND_MSB:`SSCLK_LOOP_BAND_LSB];
  wire [3:0]        input_divide_field      = loop_config_zero[`SSCLK_LOOP_INPUT_DIVIDE_FIELD_MSB:`SSCLK_LOOP_INPUT_DIVIDE_FIELD_LSB];
  wire [6:0]        feedback_multiply_field = loop_config_zero[`SSCLK_LOOP_FEEDBACK_MULTIPLY_FIELD_MSB:`SSCLK_LOOP_FEEDBACK_MULTIPLY_FIELD_LSB];
  wire [9:0]        prescaler_divide_field  = divider_config[`SSCLK_DIV_K1_MSB:`SSCLK_DIV_K1_LSB];
  wire [6:0]        output_divide_field     = divider_config[`SSCLK_DIV_K2_MSB:`SSCLK_DIV_K2_LSB];

  // Register address decode
  wire hit_sys    = (i_addr == `SSCLK_OFS_SYS_CFG);
  wire hit_loop   = (i_addr == `SSCLK_OFS_LOOP_CFG);
  wire hit_div    = (i_addr == `SSCLK_OFS_DIV_CFG);
  wire hit_status = (i_addr == `SSCLK_OFS_STATUS);

  // Software owns the fields; it must write whole coherent values, the block does not guard
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      system_clock_config <= `SSCLK_RST_SYS_CFG;
      loop_config_zero    <= `SSCLK_RST_LOOP_CFG;
      divider_config      <= `SSCLK_RST_DIV_CFG;
    end else if (i_ce && i_wr) begin
      if (hit_sys) begin
        system_clock_config <= {28'h0000000, i_wdata[3:0]};
      end else if (hit_loop) begin
        loop_config_zero <= {18'h00000, i_wdata[13:0]};
      end else if (hit_div) begin
        divider_config <= {9'h000, i_wdata[22:16], 6'h00, i_wdata[9:0]};
      end
    end
  end

  // Clock pins come from other domains and pass two flops first
  ssclk_pins_t pins_raw;
  ssclk_pins_t pins_s;
  ssclk_pins_t pins_d;
  assign pins_raw = '{ext_pin_one: i_ext_clk_pin_one, crystal: i_crystal_input_pin,
                      onchip: i_onchip_clk, wakeup: i_wakeup_clk};

  ssclk_sync #(
    .W (4)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_async (pins_raw),
    .o_sync  (pins_s)
  );

  // Delayed copy of the synchronised levels for edge detection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_d <= '0;
    end else if (i_ce) begin
      pins_d <= pins_s;
    end
  end

  // Oscillator reference shared by prescaler and PLL
  wire osc_lvl  = ref_onchip ? pins_s.onchip : pins_s.crystal;
  wire osc_prev = ref_onchip ? pins_d.onchip : pins_d.crystal;
  wire osc_edge = osc_lvl ^ osc_prev;
  wire osc_rise = osc_lvl & ~osc_prev;

  // Prescaler path: every oscillator edge is a half period, so toggling per K1 + 1 edges divides by K1 + 1
  logic presc_clk;
  logic presc_tick;
  wire  presc_run = (clock_source_select == SSCLK_SEL_GEN) && vco_bypass;

  ssclk_pulse_div #(
    .W (10)
  ) u_presc_div (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_clear (~presc_run),
    .i_pulse (osc_edge),
    .i_div   (prescaler_divide_field),
    .o_tick  (presc_tick)
  );

  // With factor one each edge toggles, so high and low times follow the source
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_clk <= 1'b0;
    end else if (i_ce) begin
      if (!presc_run) begin
        presc_clk <= osc_lvl;
      end else if (presc_tick) begin
        presc_clk <= ~presc_clk;
      end
    end
  end

  // PLL reference period, measured in system-side cycles between rising edges
  logic [15:0] per_cnt;
  logic [15:0] ref_period;
  wire         pll_run = (clock_source_select == SSCLK_SEL_GEN) && !vco_bypass;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      per_cnt    <= 16'h0000;
      ref_period <= 16'h0000;
    end else if (i_ce) begin
      if (osc_rise) begin
        per_cnt    <= 16'h0000;
        ref_period <= per_cnt + 16'h0001;
      end else if (per_cnt == 16'hffff) begin
        ref_period <= 16'h0000; // Reference lost: the VCO stops rather than runs free
      end else begin
        per_cnt <= per_cnt + 16'h0001;
      end
    end
  end

  // Multiplier steps one unit per reference edge towards its target
  logic [7:0] n_cur;
  wire  [7:0] n_target = {1'b0, feedback_multiply_field} + 8'h01;
  wire  [4:0] p_fac    = {1'b0, input_divide_field} + 5'h01;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      n_cur <= 8'h01;
    end else if (i_ce) begin
      if (!pll_run) begin
        n_cur <= 8'h01;
      end else if (osc_rise && (n_cur < n_target)) begin
        n_cur <= n_cur + 8'h01;
      end else if (osc_rise && (n_cur > n_target)) begin
        n_cur <= n_cur - 8'h01;
      end
    end
  end

  // Ideal VCO as a phase accumulator: 2*N half periods per P reference periods
  logic [21:0] vco_acc;
  logic        vco_tick;
  wire  [21:0] vco_den = {17'h00000, p_fac} * {6'h00, ref_period};
  wire  [21:0] vco_sum = vco_acc + {13'h0000, n_cur, 1'b0};
  wire         vco_hit = (vco_den != 22'h000000) && (vco_sum >= vco_den);

  // At most one VCO half period per cycle; fast settings are limited by the sampling rate
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vco_acc  <= 22'h000000;
      vco_tick <= 1'b0;
    end else if (i_ce) begin
      if (!pll_run || (vco_den == 22'h000000)) begin
        vco_acc  <= 22'h000000;
        vco_tick <= 1'b0;
      end else begin
        vco_acc  <= vco_hit ? (vco_sum - vco_den) : vco_sum;
        vco_tick <= vco_hit;
      end
    end
  end

  // Output divider K2 between VCO and system clock
  logic pll_clk;
  logic k2_tick;

  ssclk_pulse_div #(
    .W (7)
  ) u_k2_div (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_clear (~pll_run),
    .i_pulse (vco_tick),
    .i_div   (output_divide_field),
    .o_tick  (k2_tick)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pll_clk <= 1'b0;
    end else if (i_ce) begin
      if (!pll_run) begin
        pll_clk <= 1'b0;
      end else if (k2_tick) begin
        pll_clk <= ~pll_clk;
      end
    end
  end

  // Lock: running, multiplier at target, reference present
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pll_locked <= 1'b0;
    end else if (i_ce) begin
      o_pll_locked <= pll_run && (n_cur == n_target) && (ref_period != 16'h0000);
    end
  end

  // VCO band check over a fixed window; half periods per microsecond are twice the MHz
  logic [5:0] win_cnt;
  logic [8:0] vco_half;
  logic       band_ok;
  wire        win_end  = (win_cnt == 6'(`SSCLK_WIN_CYC - 1));
  wire  [8:0] band_min = (vco_band_select == 2'b00) ? 9'(2 * `SSCLK_BAND0_MIN_MHZ) : 9'(2 * `SSCLK_BAND1_MIN_MHZ);
  wire  [8:0] band_max = (vco_band_select == 2'b00) ? 9'(2 * `SSCLK_BAND0_MAX_MHZ) : 9'(2 * `SSCLK_BAND1_MAX_MHZ);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      win_cnt  <= 6'h00;
      vco_half <= 9'h000;
      band_ok  <= 1'b0;
    end else if (i_ce) begin
      if (win_end) begin
        win_cnt  <= 6'h00;
        vco_half <= 9'h000;
        band_ok  <= pll_run && (vco_half >= band_min) && (vco_half <= band_max) && !vco_band_select[1];
      end else begin
        win_cnt  <= win_cnt + 6'h01;
        vco_half <= vco_half + {8'h00, vco_tick};
      end
    end
  end

  // Dedicated FlexRay PLL: fixed VCO, only its enable and lock are modelled
  logic [5:0] fr_cnt;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fr_cnt           <= 6'h00;
      o_flexray_locked <= 1'b0;
    end else if (i_ce) begin
      if (!flexray_pll_enable) begin
        fr_cnt           <= 6'h00;
        o_flexray_locked <= 1'b0;
      end else if (fr_cnt == 6'(`SSCLK_FR_LOCK_CYC - 1)) begin
        o_flexray_locked <= 1'b1;
      end else begin
        fr_cnt <= fr_cnt + 6'h01;
      end
    end
  end

  // Clock path selected by the active key
  ssclk_key_t active_key;
  ssclk_key_t wanted_key;
  ssclk_sw_t  sw_state;
  ssclk_sw_t  next_sw_state;
  assign wanted_key = '{sel: clock_source_select, vco_bypass: vco_bypass, ref_onchip: ref_onchip};

  function automatic logic path_level(input ssclk_key_t k, input ssclk_pins_t p, input logic pr, input logic pl);
    logic lvl;
    lvl = p.wakeup;
    if (k.sel == SSCLK_SEL_DIRECT) begin
      lvl = p.ext_pin_one;
    end else if (k.sel == SSCLK_SEL_GEN) begin
      lvl = k.vco_bypass ? pr : pl;
    end
    return lvl;
  endfunction : path_level

  wire old_lvl = path_level(active_key, pins_s, presc_clk, pll_clk);
  wire new_lvl = path_level(wanted_key, pins_s, presc_clk, pll_clk);

  // Break-before-make: park low on the old path, wait for the new one to be low
  always_comb begin
    next_sw_state = sw_state;
    case (sw_state)
      SSCLK_SW_RUN:  begin
        if (wanted_key != active_key) begin
          next_sw_state = SSCLK_SW_PARK;
        end
      end
      SSCLK_SW_PARK: begin
        if (!old_lvl) begin
          next_sw_state = SSCLK_SW_ARM;
        end
      end
      SSCLK_SW_ARM:  begin
        if (!new_lvl) begin
          next_sw_state = SSCLK_SW_RUN;
        end
      end
      default:       begin
        next_sw_state = SSCLK_SW_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_state   <= SSCLK_SW_RUN;
      active_key <= '{sel: SSCLK_SEL_WAKE, vco_bypass: 1'b1, ref_onchip: 1'b0};
      o_sys_clk  <= 1'b0;
    end else if (i_ce) begin
      sw_state <= next_sw_state;
      if ((sw_state == SSCLK_SW_ARM) && !new_lvl) begin
        active_key <= wanted_key;
      end
      // Old path runs on through change cycle and PARK, so pin paths keep their high phase; pll_clk is cut once its mode is left, presc_clk follows the oscillator
      o_sys_clk <= ((sw_state == SSCLK_SW_RUN) || (sw_state == SSCLK_SW_PARK)) ? old_lvl : 1'b0;
    end
  end

  // Status word and read data, one cycle after the read strobe
  wire [31:0] status_word = {7'h00, 9'(`SSCLK_FR_VCO_MHZ), n_cur, 2'b00, o_flexray_locked, band_ok,
                             o_pll_locked, (sw_state != SSCLK_SW_RUN), active_key.sel};
  wire [31:0] rd_mux = hit_sys    ? system_clock_config :
                       hit_loop   ? loop_config_zero :
                       hit_div    ? divider_config :
                       hit_status ? status_word : 32'h0000_0000;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : ssclk_top

// *** ssclk_properties.sv ***
// Concurrent checks on the ports of the system clock source select block
`timescale 1ns/1ps
module ssclk_properties
  import ssclk_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_ext_clk_pin_one,
  input wire logic        i_crystal_input_pin,
  input wire logic        i_onchip_clk,
  input wire logic        i_wakeup_clk,
  input wire logic        o_sys_clk,
  input wire logic        o_pll_locked,
  input wire logic        o_flexray_locked
);
  logic [3:0] sh_sys;
  logic       sh_byp;
  logic [7:0] settle;
  logic [7:0] fr_cnt;
  logic       cfg_wr;
  logic       mapped;
  logic       rd_take;

  // Bus decode seen from outside the block
  assign cfg_wr  = i_ce && i_wr && (i_addr == 8'h00 || i_addr == 8'h04);
  assign mapped  = i_addr == 8'h00 || i_addr == 8'h04 || i_addr == 8'h08 || i_addr == 8'h0c;
  assign rd_take = i_ce && i_rd;

  // Shadow of the written selection, so path checks know the intended source
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_sys <= 4'h0;
      sh_byp <= 1'b1;
    end else begin
      sh_sys <= (i_ce && i_wr && i_addr == 8'h00) ? i_wdata[3:0] : sh_sys;
      sh_byp <= (i_ce && i_wr && i_addr == 8'h04) ? i_wdata[0] : sh_byp;
    end
  end

  // Settling and lock counters; a generous settle time covers the glitch-free switch
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle <= 8'h00;
      fr_cnt <= 8'h00;
    end else begin
      settle <= (cfg_wr || !i_ce) ? 8'h00 : settle + {7'h0, settle != 8'hff};
      fr_cnt <= !sh_sys[3] ? 8'h00 : fr_cnt + {7'h0, fr_cnt != 8'hff};
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_rdata_idle_zero: assert property ($past(i_ce) && !$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property ($past(rd_take && !mapped) |-> o_rdata == 32'h0)
    else $error("unmapped read returned data");
  a_status_fr_const: assert property ($past(rd_take && i_addr == 8'h0c) |-> o_rdata[31:16] == 16'h01e0)
    else $error("status upper field wrong");
  a_sys_readback: assert property ($past(rd_take && i_addr == 8'h00) |-> o_rdata == {28'h0, $past(sh_sys)})
    else $error("system config readback wrong");
  a_direct_follow: assert property (sh_sys[1:0] == 2'b11 && settle >= 8'h40 |-> o_sys_clk == $past(i_ext_clk_pin_one, 3))
    else $error("system clock not following external pin one");
  a_wakeup_follow: assert property (sh_sys[1:0] == 2'b00 && settle >= 8'h40 |-> o_sys_clk == $past(i_wakeup_clk, 3))
    else $error("system clock not following wakeup clock");
  a_active_select: assert property ($past(rd_take && i_addr == 8'h0c && settle >= 8'h40 && sh_sys[1:0] != 2'b01)
    |-> o_rdata[2:0] == {1'b0, $past(sh_sys[1:0])})
    else $error("active select in status wrong");
  a_pll_lock_mode: assert property (o_pll_locked && settle >= 8'h40 |-> sh_sys[1:0] == 2'b10 && !sh_byp)
    else $error("loop lock outside loop mode");
  a_fr_lock_delay: assert property ($rose(o_flexray_locked) |-> fr_cnt >= 8'h26 && fr_cnt <= 8'h2a)
    else $error("flexray lock delay wrong");
  a_fr_needs_en: assert property (o_flexray_locked |-> $past(sh_sys[3]))
    else $error("flexray lock without enable");
endmodule : ssclk_properties

// *** test_system_clock_source_select.sv ***
// Self-checking testbench of the system clock source select block
`timescale 1ns/1ps
module test_system_clock_source_select;
  import ssclk_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_ce = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic        o_sys_clk;
  logic        o_pll_locked;
  logic        o_flexray_locked;
  ssclk_pins_t pins = '0;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          ph = 0;
  int          per;
  int          hi;
  int          c;
  logic [31:0] rv;
  logic [31:0] pcfg[5] = '{32'h2, 32'h2, 32'h2, 32'h6, 32'h2};
  logic [31:0] pk1[5]  = '{32'h0, 32'h1, 32'h2, 32'h0, 32'h3ff};
  int          pper[5] = '{6, 12, 18, 10, 6144};

  always #12.5 i_clk = ~i_clk;

  // Source clocks: periods of 8, 6, 10 and 16 cycles; odd half periods test the divider
  always @(posedge i_clk) begin
    ph <= ph + 1;
    pins.ext_pin_one <= (ph % 8) < 4;
    pins.crystal <= (ph % 6) < 3;
    pins.onchip <= (ph % 10) < 5;
    pins.wakeup <= (ph % 16) < 8;
  end

  ssclk_top u_ssclk_top (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk_pin_one(pins.ext_pin_one),
    .i_crystal_input_pin(pins.crystal), .i_onchip_clk(pins.onchip), .i_wakeup_clk(pins.wakeup),
    .o_sys_clk(o_sys_clk), .o_pll_locked(o_pll_locked), .o_flexray_locked(o_flexray_locked));

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chkn(input string n, input int e, input int t, input int g);
    tests_run++;
    if (g < e - t || g > e + t) begin
      error_cnt++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask : chkn

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask : rd

  // Bounded wait for a level; sel selects the system clock or which lock flag
  task automatic until_lvl(input int sel, input logic v, output int n);
    n = 0;
    while ((sel == 0 ? o_sys_clk : sel == 1 ? o_pll_locked : o_flexray_locked) !== v) begin
      @(posedge i_clk);
      #1 n++;
      if (n > 20000) begin
        error_cnt++;
        $display("ERROR wait on output %0d expected %b seen %b", sel, v, ~v);
        end_of_test();
      end
    end
  endtask : until_lvl

  // Sum of k whole periods of the system clock, high time of the first
  task automatic meas(input int k);
    int t;
    until_lvl(0, 1'b0, t);
    until_lvl(0, 1'b1, t);
    per = 0;
    for (int i = 0; i < k; i++) begin
      until_lvl(0, 1'b0, t);
      if (i == 0) hi = t;
      per += t;
      until_lvl(0, 1'b1, t);
      per += t;
    end
  endtask : meas

  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(8'h00);
    chk("sys_cfg_reset", 32'h0, rv);
    rd(8'h04);
    chk("loop_cfg_reset", 32'h1, rv);
    rd(8'h08);
    chk("div_cfg_reset", 32'h0, rv);
    rd(8'h10);
    chk("unmapped_read", 32'h0, rv);
    meas(2);
    meas(1);
    chkn("wakeup_period", 16, 0, per);
    $display("Test reset and wakeup done");
    wr(8'h00, 32'h3);
    meas(2);
    meas(1);
    chkn("direct_period", 8, 0, per);
    chkn("direct_high", 4, 0, hi);
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(8'h08, 32'h5);
    @(posedge i_clk);
    i_ce <= 1'b1;
    rd(8'h08);
    chk("frozen_write", 32'h0, rv);
    $display("Test direct drive done");
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, pcfg[i]);
      wr(8'h08, pk1[i]);
      meas(2);
      meas(1);
      chkn("presc_period", pper[i], 0, per);
      chkn("presc_high", pper[i] / 2, 0, hi);
    end
    wr(8'h08, 32'h0);
    $display("Test prescaler done");
    for (int b = 0; b < 4; b++) begin
      wr(8'h04, {29'h0, b[1:0], 1'b1});
      rd(8'h04);
      chk("band_select", {29'h0, b[1:0], 1'b1}, rv);
    end
    for (int i = 0; i < 2; i++) begin
      wr(8'h04, i == 0 ? 32'h100 : 32'h208);
      wr(8'h08, 32'h10000);
      wr(8'h00, i == 0 ? 32'h2 : 32'h6);
      until_lvl(1, 1'b1, c);
      meas(2);
      meas(6);
      chkn("pll_six_periods", i == 0 ? 24 : 48, 1, per);
      rd(8'h0c);
      chk("pll_status", i == 0 ? 32'h30a : 32'h50a, {16'h0, rv[15:8], 4'h0, rv[3:0]});
    end
    $display("Test loop mode done");
    wr(8'h00, 32'ha);
    until_lvl(2, 1'b1, c);
    chkn("flexray_lock", 40, 1, c);
    wr(8'h00, 32'h2);
    until_lvl(2, 1'b0, c);
    chkn("flexray_unlock", 1, 0, c);
    $display("Test flexray done");
    end_of_test();
  end
endmodule : test_system_clock_source_select

bind ssclk_top ssclk_properties u_ssclk_properties (
  .i_clk, .i_rst_n, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ext_clk_pin_one,
  .i_crystal_input_pin, .i_onchip_clk, .i_wakeup_clk, .o_sys_clk, .o_pll_locked, .o_flexray_locked);
